/* dv/touch_panel_model.sv */
`timescale 1ns/10ps
// ************************************
// Panel and converter stand-in
// ************************************
module touch_panel_model
  import touch_report_pkg::*;
(
  input wire logic                           mclk,
  input wire logic                           srst,
  input wire logic                           conv_start,
  input wire logic                           x_axis_drive_enable,
  input wire logic                           y_axis_drive_enable,
  input wire logic                           pressed,
  input wire logic [touch_report_pkg::POS_W-1:0] x_pos,
  input wire logic [touch_report_pkg::POS_W-1:0] y_pos,
  output logic                               press_sense,
  output logic                               conv_done,
  output logic [touch_report_pkg::POS_W-1:0] x_position_sense,
  output logic [touch_report_pkg::POS_W-1:0] y_position_sense
);
  logic [4:0] wait_q;
  logic       slow_q;
  // Contact closes while the finger is down
  assign press_sense = pressed;
  // Fast and slow conversions in turn; junk on the data lines outside done
  always_ff @(posedge mclk) begin
    conv_done <= 1'b0;
    x_position_sense <= ~x_pos;
    y_position_sense <= ~y_pos;
    if (srst) begin
      wait_q <= 5'h00;
      slow_q <= 1'b0;
    end else if (conv_start) begin
      wait_q <= slow_q ? 5'h14 : 5'h01;
      slow_q <= ~slow_q;
    end else if (wait_q == 5'h01) begin
      conv_done <= 1'b1;
      // Only the driven axis yields a true position, so an axis mix-up shows
      x_position_sense <= x_axis_drive_enable ? x_pos : ~x_pos;
      y_position_sense <= y_axis_drive_enable ? y_pos : ~y_pos;
      wait_q <= 5'h00;
    end else if (wait_q != 5'h00) begin
      wait_q <= wait_q - 5'h01;
    end
  end
endmodule : touch_panel_model

/* dv/touch_panel_report_ctrl_test.sv */
`timescale 1ns/10ps
// ************************************
// Report controller bench
// ************************************
module touch_panel_report_ctrl_test;
  import touch_report_pkg::*;
  localparam int unsigned MSC = 10; // Short ms unit keeps the run brief
  logic mclk = 1'b0, srst = 1'b1, mode_load = 1'b0, single_req = 1'b0, interval_load = 1'b0, cmd_busy = 1'b0;
  logic pressed = 1'b0, x_value_invert_in = 1'b1, y_value_invert_in = 1'b1, report_ready = 1'b1;
  logic conv_start, x_axis_drive_enable, y_axis_drive_enable, x_axis_drive_level, y_axis_drive_level;
  logic detect_resistor_ctl, press_indicator, report_valid, press_sense, conv_done;
  report_mode_t mode_sel = MODE_SINGLE;
  logic [IV_W-1:0] interval_ms = 16'h0000;
  logic [POS_W-1:0] x_pos = 10'h000, y_pos = 10'h000, x_position_sense, y_position_sense;
  report_t report_data;
  report_t got[$];
  int unsigned t_q[$];
  int unsigned cyc = 0;
  int err_total = 0, compares = 0;
  bit rdy_rand = 1'b0;
  touch_panel_report_ctrl #(.MS_CYCLES(MSC)) touch_panel_report_ctrl_inst (.mclk, .srst, .mode_sel, .mode_load,
    .single_req, .interval_ms, .interval_load, .cmd_busy, .press_sense, .x_value_invert_in, .y_value_invert_in,
    .conv_done, .x_position_sense, .y_position_sense, .conv_start, .x_axis_drive_enable, .y_axis_drive_enable,
    .x_axis_drive_level, .y_axis_drive_level, .detect_resistor_ctl, .press_indicator, .report_data,
    .report_valid, .report_ready);
  touch_panel_model touch_panel_model_inst (.mclk, .srst, .conv_start, .x_axis_drive_enable, .y_axis_drive_enable,
    .pressed, .x_pos, .y_pos, .press_sense, .conv_done, .x_position_sense, .y_position_sense);
  // Free-running clock
  always #5 mclk = ~mclk;
  // Log accepted reports; ready stalls at random when asked
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    report_ready <= rdy_rand ? ($urandom % 4 != 0) : 1'b1;
    if (!srst && report_valid && report_ready) begin
      got.push_back(report_data);
      t_q.push_back(cyc);
    end
  end
  task automatic give_verdict();
    if (err_total == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  task automatic cmp_rep(string what, report_t exp, report_t seen);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : cmp_rep
  task automatic cmp_bit(string what, logic exp, logic seen);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
    end
  endtask : cmp_bit
  task automatic cmp_num(string what, int exp, int seen);
    compares++;
    if (seen != exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, seen);
    end
  endtask : cmp_num
  task automatic tick(int n);
    repeat (n) @(posedge mclk);
  endtask : tick
  // Pulse one command strobe for n edges: 0 mode, 1 single request, 2 interval
  task automatic strobe(int which, int n, report_mode_t m, logic [IV_W-1:0] iv);
    @(posedge mclk);
    mode_sel <= m;
    interval_ms <= iv;
    mode_load <= which == 0;
    single_req <= which == 1;
    interval_load <= which == 2;
    tick(n);
    {mode_load, single_req, interval_load} <= 3'h0;
  endtask : strobe
  // Bounded wait for the report log to reach n entries
  task automatic wait_reps(int n);
    for (int i = 0; i < 20000 && got.size() < n; i++) @(posedge mclk);
    if (got.size() < n) begin
      err_total++;
      give_verdict();
    end
  endtask : wait_reps
  task automatic press(logic v);
    pressed <= v;
    for (int i = 0; i < 10000 && press_indicator !== v; i++) @(posedge mclk);
    cmp_bit("press indicator", v, press_indicator);
  endtask : press
  function automatic report_t exp_press(logic [POS_W-1:0] x, logic [POS_W-1:0] y, logic xi_n, logic yi_n);
    exp_press.touch_event = 1'b1;
    exp_press.x_value = xi_n ? x : ~x;
    exp_press.y_value = yi_n ? y : ~y;
  endfunction : exp_press
  function automatic int near(int unsigned a, int unsigned b);
    return (a + 3 >= b) && (a <= b + 3);
  endfunction : near
  // Main sequence
  initial begin
    int unsigned t0;
    int np, nr;
    void'($urandom(32'hBA5BC78C));
    tick(10);
    srst <= 1'b0;
    tick(1);
    #1;
    cmp_bit("idle valid", 1'b0, report_valid);
    cmp_bit("detect phase", 1'b1, detect_resistor_ctl);
    strobe(0, 1, MODE_AUTO, 16'h0000);
    t0 = cyc;
    wait_reps(3);
    cmp_num("auto entry", 1, near(t_q[0] - t0, 3));
    cmp_num("default interval", 1, near(t_q[2] - t_q[1], 50 * MSC));
    strobe(2, 1, MODE_AUTO, 16'h0007);
    wait_reps(6);
    cmp_num("new interval", 1, near(t_q[5] - t_q[4], 7 * MSC));
    tick(10);
    cmd_busy <= 1'b1;
    tick(30);
    cmd_busy <= 1'b0;
    wait_reps(7);
    cmp_num("busy stretch", 1, near(t_q[6] - t_q[5], 7 * MSC + 30));
    strobe(0, 1, MODE_SINGLE, 16'h0007);
    tick(5);
    got.delete();
    t_q.delete();
    tick(300);
    cmp_num("stopped", 0, got.size());
    strobe(1, 2, MODE_SINGLE, 16'h0007);
    tick(100);
    cmp_num("two requests", 2, got.size());
    wait_reps(2);
    cmp_rep("idle single", REPORT_ZERO, got[1]);
    rdy_rand <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      x_pos <= i == 3 ? 10'h3FF : 10'($urandom);
      y_pos <= i == 3 ? 10'h000 : 10'($urandom);
      x_value_invert_in <= i[0];
      y_value_invert_in <= i[1];
      got.delete();
      press(1'b1);
      tick(2500);
      strobe(1, 1, MODE_SINGLE, 16'h0007);
      wait_reps(1);
      cmp_rep("pressed single", exp_press(x_pos, y_pos, x_value_invert_in, y_value_invert_in), got[0]);
      press(1'b0);
    end
    for (int m = 2; m <= 5; m++) begin
      strobe(0, 1, report_mode_t'(m), 16'h0007);
      tick(5);
      got.delete();
      press(1'b1);
      tick(3000);
      np = got.size();
      press(1'b0);
      tick(3000);
      nr = got.size() - np;
      cmp_num("press phase", 1, m == 3 ? np == 1 : m == 4 ? np == 0 : np >= 2);
      cmp_num("release phase", 1, m == 3 ? nr == 0 : (m == 4 ? nr == 1 : nr >= 1) && got[$].touch_event === 1'b0);
      if (m == 3) begin
        press(1'b1);
        tick(3000);
        cmp_num("second press", np + 1, got.size());
      end
    end
    give_verdict();
  end
endmodule : touch_panel_report_ctrl_test

/* dv/touch_report_assertions.sv */
`timescale 1ns/10ps
// ************************************
// Report and scan checks
// ************************************
module touch_report_checker
  import touch_report_pkg::*;
(
  input wire logic                          mclk,
  input wire logic                          srst,
  input wire touch_report_pkg::report_mode_t mode_sel,
  input wire logic                          mode_load,
  input wire logic                          single_req,
  input wire logic                          conv_start,
  input wire logic                          x_axis_drive_enable,
  input wire logic                          y_axis_drive_enable,
  input wire logic                          x_axis_drive_level,
  input wire logic                          y_axis_drive_level,
  input wire logic                          detect_resistor_ctl,
  input wire logic                          press_indicator,
  input wire touch_report_pkg::report_t     report_data,
  input wire logic                          report_valid,
  input wire logic                          report_ready
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  report_mode_t mode_q;
  logic [1:0]   edge_cnt_q;
  // Mirror of the selected mode
  always_ff @(posedge mclk) begin
    if (srst) mode_q <= MODE_SINGLE;
    else if (mode_load) mode_q <= mode_sel;
  end
  // Press-edge reports since the last release; saturates so a repeat shows
  always_ff @(posedge mclk) begin
    if (srst || mode_load || $fell(press_indicator)) edge_cnt_q <= 2'h0;
    else if (mode_q == MODE_PRESS_EDGE && $rose(report_valid) && edge_cnt_q != 2'h3) edge_cnt_q <= edge_cnt_q + 2'h1;
  end
  // Quiet output required, else a queued report may legally come first
  sequence single_take;
    single_req && !mode_load && mode_q == MODE_SINGLE && !report_valid && !$past(single_req) && !$past(single_req, 2);
  endsequence
  sequence auto_take;
    mode_load && mode_sel == MODE_AUTO && !report_valid;
  endsequence
  sequence out_in_two;
    ##2 report_valid;
  endsequence
  hold_report_a: assert property (report_valid && !report_ready |=> report_valid && $stable(report_data))
    else $error("report dropped or changed before accept");
  one_axis_a: assert property (!(x_axis_drive_enable && y_axis_drive_enable))
    else $error("both axes driven together");
  drive_pair_a: assert property (x_axis_drive_level == x_axis_drive_enable && y_axis_drive_level == y_axis_drive_enable)
    else $error("axis level and enable disagree");
  conv_axis_a: assert property (conv_start |-> x_axis_drive_enable ^ y_axis_drive_enable)
    else $error("conversion without one driven axis");
  single_reply_a: assert property (single_take |-> out_in_two)
    else $error("single request not answered in two cycles");
  auto_entry_a: assert property (auto_take |-> out_in_two)
    else $error("auto entry report late");
  zero_report_a: assert property (report_valid && mode_q == MODE_SINGLE && !report_data.touch_event |-> report_data.x_value == '0 && report_data.y_value == '0)
    else $error("idle single report carries position");
  edge_once_a: assert property (edge_cnt_q < 2'h2)
    else $error("second report within one press");
  reset_state_a: assert property ($fell(srst) |-> !report_valid && !press_indicator && !conv_start && detect_resistor_ctl)
    else $error("outputs not idle after reset");
endmodule : touch_report_checker
bind touch_panel_report_ctrl touch_report_checker touch_report_checker_inst (.mclk, .srst, .mode_sel, .mode_load,
  .single_req, .conv_start, .x_axis_drive_enable, .y_axis_drive_enable, .x_axis_drive_level, .y_axis_drive_level,
  .detect_resistor_ctl, .press_indicator, .report_data, .report_valid, .report_ready);

/* hw/touch_panel_report_ctrl.sv */
`timescale 1ns/10ps
// What this block does
// - Six report modes exist and a host command may select any of them at any moment.
// - The panel is sensed one axis at a time through separate enable and level outputs per axis.
// - Each X and Y value carries ten bits from the converted panel voltage.
// - A report always holds an event flag, an X value and a Y value.
// - In single mode at most one report goes out per request and none otherwise.
// - A single request with the panel released returns event, X and Y all zero.
// - A single request with the panel pressed returns event one and the measured X and Y.
// - Entering automatic mode sends the current condition at once, then one report per interval.
// - The interval is 50 ms after reset and a host command can change it.
// - Time spent processing another command stretches the running interval instead of preempting it.
// - A low X or Y invert input inverts that reported value; high leaves it normal.
// - The press indicator is high while a press is detected, one cycle behind the detected press state.
// - Press-edge mode sends one report per press and nothing until release and a new press.
module touch_panel_report_ctrl
  import touch_report_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MS_CYC
) (
  input  wire logic                         mclk,
  input  wire logic                         srst,
  input  wire touch_report_pkg::report_mode_t mode_sel,
  input  wire logic                         mode_load,
  input  wire logic                         single_req,
  input  wire logic [touch_report_pkg::IV_W-1:0] interval_ms,
  input  wire logic                         interval_load,
  input  wire logic                         cmd_busy,
  input  wire logic                         press_sense,
  input  wire logic                         x_value_invert_in,
  input  wire logic                         y_value_invert_in,
  input  wire logic                         conv_done,
  input  wire logic [touch_report_pkg::POS_W-1:0] x_position_sense,
  input  wire logic [touch_report_pkg::POS_W-1:0] y_position_sense,
  output logic                              conv_start,
  output logic                              x_axis_drive_enable,
  output logic                              y_axis_drive_enable,
  output logic                              x_axis_drive_level,
  output logic                              y_axis_drive_level,
  output logic                              detect_resistor_ctl,
  output logic                              press_indicator,
  output touch_report_pkg::report_t         report_data,
  output logic                              report_valid,
  input  wire logic                         report_ready
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  typedef enum {SC_DETECT, SC_X_SETTLE, SC_X_CONV, SC_Y_SETTLE, SC_Y_CONV} scan_state_t;

  logic [1:0]       press_sync_q;
  logic [1:0]       xinv_sync_q;
  logic [1:0]       yinv_sync_q;
  scan_state_t      scan_q;
  logic [CNT_W-1:0] settle_q;
  logic             settle_end;
  logic             pressed_q;
  logic             press_rise;
  logic             press_fall;
  logic [POS_W-1:0] x_pos_q;
  logic [POS_W-1:0] y_pos_q;
  report_mode_t     mode_q;
  logic [CNT_W-1:0] ms_cnt_q;
  logic             ms_tick;
  logic [IV_W-1:0]  iv_len_q;
  logic [IV_W-1:0]  iv_cnt_q;
  logic             iv_run;
  logic             iv_restart;
  logic             iv_tick;
  logic             trig;
  report_t          trig_rpt;
  logic             pend_q;
  report_t          pend_rpt_q;

  // Only the second stage of each pair is read
  always_ff @(posedge mclk) begin
    if (srst) begin
      press_sync_q <= 2'h0;
      xinv_sync_q  <= 2'h3;
      yinv_sync_q  <= 2'h3;
    end else begin
      press_sync_q <= {press_sync_q[0], press_sense};
      xinv_sync_q  <= {xinv_sync_q[0], x_value_invert_in};
      yinv_sync_q  <= {yinv_sync_q[0], y_value_invert_in};
    end
  end

  // ************************************************************
  // Panel scan: detect, then X axis, then Y axis
  // ************************************************************
  // Each phase settles before sampling; a released panel skips conversion
  always_ff @(posedge mclk) begin
    if (srst) begin
      scan_q <= SC_DETECT;
    end else begin
      case (scan_q)
        SC_DETECT:   scan_q <= (settle_end && press_sync_q[1]) ? SC_X_SETTLE : SC_DETECT;
        SC_X_SETTLE: scan_q <= settle_end ? SC_X_CONV : SC_X_SETTLE;
        SC_X_CONV:   scan_q <= conv_done ? SC_Y_SETTLE : SC_X_CONV;
        SC_Y_SETTLE: scan_q <= settle_end ? SC_Y_CONV : SC_Y_SETTLE;
        SC_Y_CONV:   scan_q <= conv_done ? SC_DETECT : SC_Y_CONV;
        default:     scan_q <= SC_DETECT;
      endcase
    end
  end

  // Settle timer restarts at every phase end and idles while a conversion runs
  assign settle_end = (settle_q == CNT_W'(SETTLE_CYC - 1));
  always_ff @(posedge mclk) begin
    if (srst || settle_end || (scan_q == SC_X_CONV) || (scan_q == SC_Y_CONV)) begin
      settle_q <= '0;
    end else begin
      settle_q <= settle_q + CNT_W'(1);
    end
  end

  // Drive outputs registered from the current scan state, so they follow it one cycle late
  always_ff @(posedge mclk) begin
    if (srst) begin
      x_axis_drive_enable <= 1'b0;
      y_axis_drive_enable <= 1'b0;
      x_axis_drive_level  <= 1'b0;
      y_axis_drive_level  <= 1'b0;
      detect_resistor_ctl <= 1'b1;
      conv_start          <= 1'b0;
    end else begin
      x_axis_drive_enable <= (scan_q == SC_X_SETTLE) || (scan_q == SC_X_CONV);
      y_axis_drive_enable <= (scan_q == SC_Y_SETTLE) || (scan_q == SC_Y_CONV);
      x_axis_drive_level  <= (scan_q == SC_X_SETTLE) || (scan_q == SC_X_CONV);
      y_axis_drive_level  <= (scan_q == SC_Y_SETTLE) || (scan_q == SC_Y_CONV);
      detect_resistor_ctl <= (scan_q == SC_DETECT);
      conv_start          <= ((scan_q == SC_X_SETTLE) || (scan_q == SC_Y_SETTLE))
                             && (settle_q == CNT_W'(SETTLE_CYC - 1));
    end
  end

  // Press state follows each detect sample
  assign press_rise = (scan_q == SC_DETECT) && (settle_q == CNT_W'(SETTLE_CYC - 1))
                      && press_sync_q[1] && !pressed_q;
  assign press_fall = (scan_q == SC_DETECT) && (settle_q == CNT_W'(SETTLE_CYC - 1))
                      && !press_sync_q[1] && pressed_q;

  always_ff @(posedge mclk) begin
    if (srst) begin
      pressed_q       <= 1'b0;
      press_indicator <= 1'b0;
    end else begin
      if (press_rise) begin
        pressed_q <= 1'b1;
      end else if (press_fall) begin
        pressed_q <= 1'b0;
      end
      press_indicator <= pressed_q;
    end
  end

  // Positions captured with inversion applied, so reports never need it
  always_ff @(posedge mclk) begin
    if (srst) begin
      x_pos_q <= '0;
      y_pos_q <= '0;
    end else begin
      if ((scan_q == SC_X_CONV) && conv_done) begin
        x_pos_q <= x_position_sense ^ {POS_W{!xinv_sync_q[1]}};
      end
      if ((scan_q == SC_Y_CONV) && conv_done) begin
        y_pos_q <= y_position_sense ^ {POS_W{!yinv_sync_q[1]}};
      end
    end
  end

  // ************************************************************
  // Mode, interval and report triggers
  // ************************************************************
  // Selecting single, press-edge or release-edge mode stops periodic reports, as does a release in the two pressed modes
  always_ff @(posedge mclk) begin
    if (srst) begin
      mode_q   <= MODE_SINGLE;
      iv_len_q <= IV_RESET_MS;
    end else begin
      if (mode_load) begin
        mode_q <= mode_sel;
      end
      if (interval_load) begin
        iv_len_q <= interval_ms;
      end
    end
  end

  assign iv_run = (mode_q == MODE_AUTO)
                  || (pressed_q && ((mode_q == MODE_WHILE_PRESSED) || (mode_q == MODE_BOTH_EDGES)));
  assign iv_restart = mode_load || press_rise;

  // Busy time freezes the millisecond prescaler, stretching the interval
  always_ff @(posedge mclk) begin
    if (srst || iv_restart) begin
      ms_cnt_q <= '0;
    end else if (!cmd_busy) begin
      if (ms_cnt_q == CNT_W'(MS_CYCLES - 1)) begin
        ms_cnt_q <= '0;
      end else begin
        ms_cnt_q <= ms_cnt_q + CNT_W'(1);
      end
    end
  end
  assign ms_tick = !cmd_busy && (ms_cnt_q == CNT_W'(MS_CYCLES - 1));

  always_ff @(posedge mclk) begin
    if (srst || iv_restart || !iv_run) begin
      iv_cnt_q <= '0;
    end else if (ms_tick) begin
      if (iv_cnt_q >= iv_len_q - IV_W'(1)) begin
        iv_cnt_q <= '0;
      end else begin
        iv_cnt_q <= iv_cnt_q + IV_W'(1);
      end
    end
  end
  assign iv_tick = iv_run && !iv_restart && ms_tick && (iv_cnt_q >= iv_len_q - IV_W'(1));

  // Trigger and record content per mode
  always_comb begin
    trig     = 1'b0;
    trig_rpt = REPORT_ZERO;
    case (mode_q)
      MODE_SINGLE: begin
        trig = single_req && !mode_load;
        if (pressed_q) begin
          trig_rpt = '{touch_event: 1'b1, x_value: x_pos_q, y_value: y_pos_q};
        end else begin
          trig_rpt = REPORT_ZERO;
        end
      end
      MODE_AUTO: begin
        trig     = iv_tick;
        trig_rpt = pressed_q ? '{touch_event: 1'b1, x_value: x_pos_q, y_value: y_pos_q} : REPORT_ZERO;
      end
      MODE_WHILE_PRESSED, MODE_BOTH_EDGES: begin
        trig     = press_rise || iv_tick || press_fall;
        trig_rpt = '{touch_event: !press_fall, x_value: x_pos_q, y_value: y_pos_q};
      end
      MODE_PRESS_EDGE: begin
        trig     = press_rise;
        trig_rpt = '{touch_event: 1'b1, x_value: x_pos_q, y_value: y_pos_q};
      end
      MODE_RELEASE_EDGE: begin
        trig     = press_fall;
        trig_rpt = '{touch_event: 1'b0, x_value: x_pos_q, y_value: y_pos_q};
      end
      default: begin
        trig     = 1'b0;
        trig_rpt = REPORT_ZERO;
      end
    endcase
    // Entering auto mode reports the present condition at once
    if (mode_load && (mode_sel == MODE_AUTO)) begin
      trig     = 1'b1;
      trig_rpt = pressed_q ? '{touch_event: 1'b1, x_value: x_pos_q, y_value: y_pos_q} : REPORT_ZERO;
    end
  end

  // ************************************************************
  // Report output with one waiting slot
  // ************************************************************
  // A trigger while the slot is full replaces it; older data is stale anyway
  always_ff @(posedge mclk) begin
    if (srst) begin
      pend_q     <= 1'b0;
      pend_rpt_q <= REPORT_ZERO;
    end else begin
      if (trig) begin
        pend_q     <= 1'b1;
        pend_rpt_q <= trig_rpt;
      end else if (pend_q && (!report_valid || report_ready)) begin
        pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      report_valid <= 1'b0;
      report_data  <= REPORT_ZERO;
    end else begin
      if (pend_q && (!report_valid || report_ready)) begin
        report_valid <= 1'b1;
        report_data  <= pend_rpt_q;
      end else if (report_ready) begin
        report_valid <= 1'b0;
      end
    end
  end

endmodule : touch_panel_report_ctrl

/* hw/touch_report_pkg.sv */
package touch_report_pkg;

  // ************************************************************
  // Widths and timing
  // ************************************************************
  localparam int unsigned POS_W          = 10;        // Converter resolution
  localparam int unsigned IV_W           = 16;        // Interval field, in ms
  localparam int unsigned CLK_PERIOD_NS  = 10;        // mclk at 100 MHz
  localparam int unsigned SETTLE_NS      = 10000;     // Panel settle per phase
  localparam int unsigned SETTLE_CYC     = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MS_NS          = 1000000;   // One interval unit
  localparam int unsigned MS_CYC         = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned CNT_W          = 17;        // Holds MS_CYC
  localparam logic [IV_W-1:0] IV_RESET_MS = 16'h0032; // 50 ms after reset

  // ************************************************************
  // Report modes and report record
  // ************************************************************
  typedef enum logic [2:0] {
    MODE_SINGLE,
    MODE_AUTO,
    MODE_WHILE_PRESSED,
    MODE_PRESS_EDGE,
    MODE_RELEASE_EDGE,
    MODE_BOTH_EDGES
  } report_mode_t;

  typedef struct packed {
    logic             touch_event;
    logic [POS_W-1:0] x_value;
    logic [POS_W-1:0] y_value;
  } report_t;

  localparam report_t REPORT_ZERO = '0;

endpackage : touch_report_pkg
